// *** cmfc_pkg.sv ***
package cmfc_pkg;

	// Register byte offsets
	localparam logic [7:0] CMFC_MODE_OFF   = 8'h00;
	localparam logic [7:0] CMFC_FB_OFF     = 8'h04;
	localparam logic [7:0] CMFC_HOLD_OFF   = 8'h08;
	localparam logic [7:0] CMFC_SYNC_OFF   = 8'h0C;
	localparam logic [7:0] CMFC_STATUS_OFF = 8'h10;

	// Mode field position within config_word_eleven
	localparam int CMFC_MODE_LSB = 27;
	localparam int CMFC_MODE_MSB = 31;

	// Mode codes
	localparam logic [4:0] CMFC_MODE_DUAL_INT    = 5'h00;
	localparam logic [4:0] CMFC_MODE_DUAL_INT_ZD = 5'h02;
	localparam logic [4:0] CMFC_MODE_DUAL_EXT    = 5'h03;
	localparam logic [4:0] CMFC_MODE_DUAL_EXT_ZD = 5'h05;
	localparam logic [4:0] CMFC_MODE_SGL_INT     = 5'h06;
	localparam logic [4:0] CMFC_MODE_SGL_INT_ZD  = 5'h08;
	localparam logic [4:0] CMFC_MODE_SGL_EXT     = 5'h0B;
	localparam logic [4:0] CMFC_MODE_DIST        = 5'h10;

	// Feedback register fields
	localparam int CMFC_FB_EN_BIT  = 8;
	localparam logic [2:0] CMFC_FB_SEL_EXT = 3'h6;
	localparam logic [2:0] CMFC_FB_SEL_MAX_OUT = 3'h5;

	// Holdover register fields
	localparam int CMFC_HOLD_MODE_LSB = 0;
	localparam int CMFC_HOLD_FORCE_BIT = 2;
	localparam int CMFC_HOLD_TRACK_BIT = 3;
	localparam int CMFC_HOLD_MANDAC_BIT = 4;
	localparam int CMFC_HOLD_DLDDIS_BIT = 5;
	localparam int CMFC_HOLD_RAIL_BIT = 6;
	localparam logic [1:0] CMFC_HOLD_MODE_ON = 2'h2;

	// Sync register fields
	localparam int CMFC_SYNC_QUALIFY_SELECT_BIT = 0;
	localparam int CMFC_SYNC_EN_BIT   = 1;
	localparam int CMFC_OUT2_PD_BIT   = 2;
	localparam int CMFC_NOSYNC_LSB    = 8;

	// Reset values
	localparam logic [31:0] CMFC_MODE_RST = 32'h0000_0000;
	localparam logic [31:0] CMFC_FB_RST   = 32'h0000_0000;
	localparam logic [31:0] CMFC_HOLD_RST = 32'h0000_0000;
	localparam logic [31:0] CMFC_SYNC_RST = 32'h0000_0002;

	// Decoded routing state
	typedef struct packed {
		logic       clean_loop_on;
		logic       synth_loop_on;
		logic       ext_osc;
		logic       zero_delay;
		logic       dist_only;
		logic       reserved;
	} cmfc_mode_type;

	typedef struct packed {
		logic       fb_mux_on;
		logic       fb_external;
		logic [2:0] fb_output;
		logic       clean_fb_from_out;
		logic       synth_fb_from_out;
		logic       ref1_is_feedback;
		logic [1:0] clean_ref_src;
		logic       synth_ref_osc;
		logic       dist_from_ref1;
		logic       osc_buffer_on;
		logic       osc_to_outputs;
		logic       ext_osc_on_fb_pin;
		logic       freeze_tune;
		logic       fb_div_chain;
	} cmfc_route_type;

endpackage

// *** cmfc_core.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Decode mode; dual loop codes 0,2,3,5
// - Codes 6,8,11 single loop; 16 distribution
// - Zero-delay routes selected output to feedback divider
// - Feedback mux powered only when enabled
// - Feedback select: output subset or external pin
// - Dual loop: reference 0-2, oscillator feeds synthesis
// - Single loop: cleaning loop off, oscillator references
// - Single zero-delay: synthesis feedback from output
// - External feedback enters via reference input 1 pin
// - Distribution: reference 1 drives six outputs
// - Single/distribution: oscillator buffer, two outputs option
// - Holdover freezes cleaning loop tuning voltage
// - Output divide chains with cleaning feedback divider
module cmfc_core
	import cmfc_pkg::*;
(
	input  wire logic        core_clk_in,
	input  wire logic        rst_n_in,
	input  wire logic        psel_in,
	input  wire logic        penable_in,
	input  wire logic        pwrite_in,
	input  wire logic [7:0]  paddr_in,
	input  wire logic [31:0] pwdata_in,
	input  wire logic [1:0]  ref_select_in,
	input  wire logic        ref_lost_in,
	output logic      [31:0] prdata_out,
	output logic             pready_out,
	output logic             pslverr_out,
	output cmfc_route_type   route_out
);

	logic [31:0]    mode_q;
	logic [31:0]    fb_q;
	logic [31:0]    hold_q;
	logic [31:0]    sync_q;
	logic [2:0]     lost_sync_q;
	logic           lost_q;
	logic           access;
	logic           addr_ok;
	logic [4:0]     mode_code;
	cmfc_mode_type  mode_dec;
	cmfc_route_type route_d;
	logic [2:0]     fb_sel;
	logic           holdover_on;

	assign access    = psel_in && penable_in;
	assign mode_code = mode_q[CMFC_MODE_MSB:CMFC_MODE_LSB];
	assign fb_sel    = fb_q[2:0];

	// Address decode for mapped words
	always_comb begin
		case (paddr_in)
			CMFC_MODE_OFF, CMFC_FB_OFF, CMFC_HOLD_OFF, CMFC_SYNC_OFF, CMFC_STATUS_OFF: begin
				addr_ok = 1'b1;
			end
			default: begin
				addr_ok = 1'b0;
			end
		endcase
	end

	// Configuration word writes
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			mode_q <= CMFC_MODE_RST;
			fb_q   <= CMFC_FB_RST;
			hold_q <= CMFC_HOLD_RST;
			sync_q <= CMFC_SYNC_RST;
		end else if (access && pwrite_in && pready_out) begin
			// Write lands at the edge where the master samples ready high
			case (paddr_in)
				CMFC_MODE_OFF: begin
					mode_q <= pwdata_in;
				end
				CMFC_FB_OFF: begin
					fb_q <= pwdata_in;
				end
				CMFC_HOLD_OFF: begin
					hold_q <= pwdata_in;
				end
				CMFC_SYNC_OFF: begin
					sync_q <= pwdata_in;
				end
				default: begin
				end
			endcase
		end
	end

	// APB answer one cycle after access phase starts
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
			prdata_out  <= 32'h0000_0000;
		end else if (access && !pready_out) begin
			pready_out  <= 1'b1;
			pslverr_out <= !addr_ok;
			prdata_out  <= 32'h0000_0000;
			if (!pwrite_in) begin
				case (paddr_in)
					CMFC_MODE_OFF: begin
						prdata_out <= mode_q;
					end
					CMFC_FB_OFF: begin
						prdata_out <= fb_q;
					end
					CMFC_HOLD_OFF: begin
						prdata_out <= hold_q;
					end
					CMFC_SYNC_OFF: begin
						prdata_out <= sync_q;
					end
					CMFC_STATUS_OFF: begin
						prdata_out <= {16'h0000, 2'h0, route_out.fb_mux_on,
							route_out.freeze_tune, lost_q, mode_dec.reserved,
							mode_dec.dist_only, mode_dec.zero_delay, mode_dec.ext_osc,
							mode_dec.synth_loop_on, mode_dec.clean_loop_on, mode_code};
					end
					default: begin
					end
				endcase
			end
		end else begin
			pready_out  <= 1'b0;
			pslverr_out <= 1'b0;
		end
	end

	// Reference-lost pin synchroniser; change counts when stages agree
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			lost_sync_q <= 3'h0;
			lost_q      <= 1'b0;
		end else begin
			lost_sync_q <= {lost_sync_q[1:0], ref_lost_in};
			if (lost_sync_q[1] == lost_sync_q[2]) begin
				lost_q <= lost_sync_q[2];
			end
		end
	end

	// Mode decoder
	always_comb begin
		mode_dec = '0;
		case (mode_code)
			CMFC_MODE_DUAL_INT: begin
				mode_dec.clean_loop_on = 1'b1;
				mode_dec.synth_loop_on = 1'b1;
			end
			CMFC_MODE_DUAL_INT_ZD: begin
				mode_dec.clean_loop_on = 1'b1;
				mode_dec.synth_loop_on = 1'b1;
				mode_dec.zero_delay    = 1'b1;
			end
			CMFC_MODE_DUAL_EXT: begin
				mode_dec.clean_loop_on = 1'b1;
				mode_dec.synth_loop_on = 1'b1;
				mode_dec.ext_osc       = 1'b1;
			end
			CMFC_MODE_DUAL_EXT_ZD: begin
				mode_dec.clean_loop_on = 1'b1;
				mode_dec.synth_loop_on = 1'b1;
				mode_dec.ext_osc       = 1'b1;
				mode_dec.zero_delay    = 1'b1;
			end
			CMFC_MODE_SGL_INT: begin
				mode_dec.synth_loop_on = 1'b1;
			end
			CMFC_MODE_SGL_INT_ZD: begin
				mode_dec.synth_loop_on = 1'b1;
				mode_dec.zero_delay    = 1'b1;
			end
			CMFC_MODE_SGL_EXT: begin
				mode_dec.synth_loop_on = 1'b1;
				mode_dec.ext_osc       = 1'b1;
			end
			CMFC_MODE_DIST: begin
				mode_dec.dist_only = 1'b1;
			end
			default: begin
				mode_dec.reserved = 1'b1;
			end
		endcase
	end

	assign holdover_on = (hold_q[CMFC_HOLD_MODE_LSB +: 2] == CMFC_HOLD_MODE_ON)
		&& !hold_q[CMFC_HOLD_FORCE_BIT];

	// Routing derived from decoded mode and feedback settings
	always_comb begin
		route_d = '0;
		// mux powered only by its enable
		route_d.fb_mux_on = fb_q[CMFC_FB_EN_BIT];
		// output subset or external pin; external forced off in ext-oscillator modes
		route_d.fb_external = route_d.fb_mux_on && (fb_sel == CMFC_FB_SEL_EXT)
			&& !mode_dec.ext_osc && mode_dec.zero_delay;
		route_d.fb_output = (fb_sel <= CMFC_FB_SEL_MAX_OUT) ? fb_sel : 3'h0;
		// dual-loop zero-delay feeds cleaning divider; divide chain
		route_d.clean_fb_from_out = mode_dec.zero_delay && mode_dec.clean_loop_on
			&& route_d.fb_mux_on;
		route_d.fb_div_chain = route_d.clean_fb_from_out;
		route_d.synth_fb_from_out = mode_dec.zero_delay && !mode_dec.clean_loop_on
			&& route_d.fb_mux_on;
		// external feedback via reference input 1 pin
		route_d.ref1_is_feedback = route_d.fb_external && mode_dec.zero_delay;
		if (mode_dec.clean_loop_on) begin
			route_d.clean_ref_src = (ref_select_in == 2'h3) ? 2'h0 : ref_select_in;
		end
		route_d.synth_ref_osc = mode_dec.synth_loop_on;
		route_d.dist_from_ref1 = mode_dec.dist_only;
		route_d.osc_buffer_on  = !mode_dec.reserved;
		route_d.osc_to_outputs = (mode_dec.synth_loop_on && !mode_dec.clean_loop_on)
			|| mode_dec.dist_only;
		route_d.ext_osc_on_fb_pin = mode_dec.ext_osc;
		route_d.freeze_tune = mode_dec.clean_loop_on && holdover_on && lost_q;
	end

	// Registered routing outputs
	always_ff @(posedge core_clk_in) begin
		if (!rst_n_in) begin
			route_out <= '0;
		end else begin
			route_out <= route_d;
		end
	end

endmodule
`default_nettype wire

// *** cmfc_core_monitor.sv ***
`timescale 1ns/1ps
`default_nettype none
module cmfc_core_monitor
	import cmfc_pkg::*;
(
	input wire logic           core_clk_in,
	input wire logic           rst_n_in,
	input wire logic           psel_in,
	input wire logic           penable_in,
	input wire logic           pready_out,
	input wire logic           pslverr_out,
	input wire cmfc_route_type route_out
);
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rst_n_in);
	// Access phase still waiting for its answer
	sequence s_acc;
		psel_in && penable_in && !pready_out;
	endsequence
	property p_ans; s_acc |=> pready_out; endproperty
	property p_pulse; pready_out |=> !pready_out; endproperty
	property p_err; pslverr_out |-> pready_out; endproperty
	property p_idle; !psel_in |=> !pready_out; endproperty
	property p_ext; route_out.ext_osc_on_fb_pin |-> !route_out.fb_external; endproperty
	property p_pin; route_out.fb_external |-> route_out.ref1_is_feedback; endproperty
	property p_sgl; route_out.synth_fb_from_out |-> !route_out.clean_fb_from_out; endproperty
	property p_dist; route_out.dist_from_ref1 |-> !route_out.synth_ref_osc; endproperty
	property p_frz; route_out.freeze_tune |-> !route_out.dist_from_ref1; endproperty
	a_ans: assert property (p_ans) else $error("no answer after one wait");
	a_pulse: assert property (p_pulse) else $error("ready held too long");
	a_err: assert property (p_err) else $error("error without ready");
	a_idle: assert property (p_idle) else $error("ready while idle");
	a_ext: assert property (p_ext) else $error("external feedback on oscillator pin");
	a_pin: assert property (p_pin) else $error("external feedback not on ref 1");
	a_sgl: assert property (p_sgl) else $error("both loops fed back");
	a_dist: assert property (p_dist) else $error("synth ref in distribution");
	a_frz: assert property (p_frz) else $error("freeze in distribution");
endmodule
`default_nettype wire

// *** cmfc_ref_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// Reference sources: loss arrives off the clock grid
module cmfc_ref_model (
	input wire logic        lose_in,
	input wire logic [1:0]  sel_in,
	output logic     [1:0]  ref_select_out,
	output logic            ref_lost_out
);
	assign ref_select_out = sel_in;
	// Asynchronous loss indication
	always @(lose_in) ref_lost_out <= #2.3 lose_in;
	initial ref_lost_out = 1'b0;
endmodule
`default_nettype wire

// *** clock_mode_feedback_control_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module clock_mode_feedback_control_test;
	import cmfc_pkg::*;
	logic core_clk_in = 0, rst_n_in = 0, psel_in = 0, penable_in = 0, pwrite_in = 0, lose = 0;
	logic [7:0] paddr_in = 0;
	logic [31:0] pwdata_in = 0, prdata_out, q;
	logic [1:0] sel = 0, ref_select_in;
	logic ref_lost_in, pready_out, pslverr_out, e;
	cmfc_route_type route_out;
	int n_errors = 0, checked = 0;
	always #2.5 core_clk_in = ~core_clk_in;
	cmfc_core i_dut (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
		.penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
		.pwdata_in(pwdata_in), .ref_select_in(ref_select_in), .ref_lost_in(ref_lost_in),
		.prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
		.route_out(route_out));
	cmfc_ref_model i_ref (.lose_in(lose), .sel_in(sel), .ref_select_out(ref_select_in),
		.ref_lost_out(ref_lost_in));
	task automatic wrap_up();
		$display("n_errors %0d checked %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One APB transfer, setup then access until ready
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge core_clk_in);
		psel_in <= 1'b1; pwrite_in <= wr; paddr_in <= a; pwdata_in <= d;
		@(posedge core_clk_in);
		penable_in <= 1'b1;
		do begin @(posedge core_clk_in); k++; end while (pready_out !== 1'b1 && k < 20);
		q = prdata_out; e = pslverr_out;
		psel_in <= 1'b0; penable_in <= 1'b0;
		if (k >= 20) begin n_errors++; wrap_up(); end
	endtask
	function automatic logic [5:0] st(input logic [4:0] m);
		case (m)
			5'h00: st = 6'h03; 5'h02: st = 6'h0B; 5'h03: st = 6'h07; 5'h05: st = 6'h0F;
			5'h06: st = 6'h02; 5'h08: st = 6'h0A; 5'h0B: st = 6'h06; 5'h10: st = 6'h10;
			default: st = 6'h20;
		endcase
	endfunction
	// Reset values, unmapped address, read-only status
	task automatic t_regs();
		apb(0, CMFC_MODE_OFF, 0); cmp(q, CMFC_MODE_RST);
		apb(0, CMFC_SYNC_OFF, 0); cmp(q, CMFC_SYNC_RST);
		apb(0, 8'h14, 0); cmp({q[30:0], e}, 32'h1);
		apb(1, CMFC_STATUS_OFF, 32'h1F); apb(0, CMFC_STATUS_OFF, 0); cmp(q[4:0], 5'h0);
		apb(1, CMFC_SYNC_OFF, 32'h3); apb(0, CMFC_SYNC_OFF, 0); cmp(q, 32'h3);
	endtask
	// Every mode code plus one reserved code
	task automatic t_modes();
		logic [4:0] m[9] = '{5'h00, 5'h02, 5'h03, 5'h05, 5'h06, 5'h08, 5'h0B, 5'h10, 5'h01};
		foreach (m[i]) begin
			apb(1, CMFC_MODE_OFF, {m[i], 27'h0}); apb(0, CMFC_STATUS_OFF, 0);
			cmp(q[10:0], {st(m[i]), m[i]});
		end
	endtask
	// Feedback routing per mode and select
	task automatic t_fb();
		logic [4:0] m[6] = '{5'h02, 5'h02, 5'h08, 5'h02, 5'h05, 5'h10};
		logic [8:0] f[6] = '{9'h103, 9'h003, 9'h103, 9'h106, 9'h106, 9'h000};
		logic [5:0] x[6] = '{6'h28, 6'h00, 6'h24, 6'h32, 6'h00, 6'h01};
		logic [5:0] k[6] = '{6'h3F, 6'h20, 6'h3C, 6'h36, 6'h10, 6'h01};
		foreach (m[i]) begin
			apb(1, CMFC_MODE_OFF, {m[i], 27'h0}); apb(1, CMFC_FB_OFF, {23'h0, f[i]});
			@(posedge core_clk_in); #1;
			cmp({route_out.fb_mux_on, route_out.fb_external, route_out.clean_fb_from_out,
				route_out.synth_fb_from_out, route_out.ref1_is_feedback,
				route_out.dist_from_ref1} & k[i], x[i]);
		end
		cmp(route_out.fb_output, 3'h0);
	endtask
	// Holdover freeze and reference choice in dual loop
	task automatic t_hold();
		int k;
		apb(1, CMFC_MODE_OFF, 0); apb(1, CMFC_HOLD_OFF, 32'h2);
		for (int s = 0; s < 4; s++) begin
			sel <= s[1:0]; repeat (3) @(posedge core_clk_in);
			cmp(route_out.clean_ref_src, (s == 3) ? 2'h0 : s[1:0]);
		end
		lose <= 1'b1; k = 0;
		do begin @(posedge core_clk_in); #1 k++; end while (!route_out.freeze_tune && k < 20);
		cmp(route_out.freeze_tune, 1'b1);
		apb(1, CMFC_HOLD_OFF, 32'h6); repeat (2) @(posedge core_clk_in);
		cmp(route_out.freeze_tune, 1'b0);
		lose <= 1'b0;
	endtask
	initial begin
		repeat (20) @(posedge core_clk_in);
		rst_n_in <= 1'b1;
		t_regs();
		t_modes();
		t_fb();
		t_hold();
		wrap_up();
	end
endmodule
bind cmfc_core cmfc_core_monitor i_mon (.core_clk_in(core_clk_in), .rst_n_in(rst_n_in),
	.psel_in(psel_in), .penable_in(penable_in), .pready_out(pready_out),
	.pslverr_out(pslverr_out), .route_out(route_out));
`default_nettype wire
